// *** rtl/integer_arith_unit.sv ***
`timescale 1ns/1ps
module integer_arith_unit (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire int_arith_pkg::arith_req_t i_req,
  output logic o_busy,
  output logic o_done,
  output int_arith_pkg::arith_rsp_t o_rsp
);
  import int_arith_pkg::*;

  // Unit sequencing: one-cycle ops finish at once, divide iterates
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DIVIDE = 2'b10
  } unit_state_t;

  unit_state_t state_q;
  logic done_q;
  arith_rsp_t rsp_q;
  logic [31:0] rem_q; // Running remainder, upper part, for divide
  logic [15:0] quo_q; // Quotient being shifted in
  logic [15:0] divisor_q;
  logic [4:0] steps_q;
  logic word_q;
  arith_rsp_t comb_rsp; // One-cycle result
  logic carry_in;
  // Trial subtraction of the divisor from the remainder shifted by one bit
  logic [32:0] div_trial;

  // Binary add or subtract at byte or word size with carry in
  function automatic logic [16:0] bin_addsub(input logic [15:0] a, input logic [15:0] b,
                                             input logic cin, input logic sub,
                                             input logic word);
    logic [16:0] r;
    logic [8:0] r8;
    r = 17'h00000;
    r8 = 9'h000;
    if (word) begin
      r = sub ? ({1'b0, a} - {1'b0, b} - {16'h0000, cin})
              : ({1'b0, a} + {1'b0, b} + {16'h0000, cin});
    end else begin
      r8 = sub ? ({1'b0, a[7:0]} - {1'b0, b[7:0]} - {8'h00, cin})
               : ({1'b0, a[7:0]} + {1'b0, b[7:0]} + {8'h00, cin});
      r = {r8[8], 8'h00, r8[7:0]};
    end
    return r;
  endfunction

  // Packed decimal byte add or subtract; bit 8 is decimal carry or borrow
  function automatic logic [8:0] bcd_addsub(input logic [7:0] a, input logic [7:0] b,
                                            input logic cin, input logic sub);
    logic [4:0] lo;
    logic [4:0] hi;
    logic c1;
    lo = 5'h00;
    hi = 5'h00;
    c1 = 1'b0;
    if (!sub) begin
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      if (lo > 5'h09) lo = lo + 5'h06;
      c1 = lo[4];
      hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, c1};
      if (hi > 5'h09) hi = hi + 5'h06;
    end else begin
      lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      if (lo[4]) lo = lo - 5'h06;
      c1 = lo[4];
      hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, c1};
      if (hi[4]) hi = hi - 5'h06;
    end
    return {hi[4], hi[3:0], lo[3:0]};
  endfunction

  // Carry comes from the flags register held by the control side
  assign carry_in = i_req.condition_flags_reg[CARRY_BIT_POS];

  // Single-cycle datapath for every operation except divide
  always_comb begin
    logic [16:0] s;
    logic [8:0] d;
    s = 17'h00000;
    d = 9'h000;
    comb_rsp = '0;
    unique case (i_req.op)
      OP_ADD, OP_ADD_SPECIAL: begin
        s = bin_addsub(i_req.dest_operand[15:0], i_req.source_operand, 1'b0, 1'b0,
                       i_req.is_word);
        comb_rsp.result = {16'h0000, s[15:0]};
        comb_rsp.carry_out = s[16];
      end
      OP_SUB, OP_SUB_SPECIAL, OP_COMPARE: begin
        // Compare computes the difference only for its carry; result is the destination
        s = bin_addsub(i_req.dest_operand[15:0], i_req.source_operand, 1'b0, 1'b1,
                       i_req.is_word);
        comb_rsp.result = (i_req.op == OP_COMPARE) ? i_req.dest_operand : {16'h0000, s[15:0]};
        comb_rsp.carry_out = s[16];
      end
      OP_ADD_WITH_CARRY, OP_SUB_WITH_BORROW: begin
        s = bin_addsub(i_req.dest_operand[15:0], i_req.source_operand, carry_in,
                       i_req.op == OP_SUB_WITH_BORROW, i_req.is_word);
        comb_rsp.result = {16'h0000, s[15:0]};
        comb_rsp.carry_out = s[16];
      end
      OP_BCD_ADD, OP_BCD_SUB: begin
        // Decimal ops are byte only; the word flag is ignored
        d = bcd_addsub(i_req.dest_operand[7:0], i_req.source_operand[7:0], carry_in,
                       i_req.op == OP_BCD_SUB);
        comb_rsp.result = {24'h000000, d[7:0]};
        comb_rsp.carry_out = d[8];
      end
      OP_UNSIGNED_MULTIPLY: begin
        if (i_req.is_word) begin
          comb_rsp.result = i_req.dest_operand[15:0] * i_req.source_operand;
        end else begin
          // Widen both factors first, or the product is cut to eight bits
          comb_rsp.result = {16'h0000, 16'(i_req.dest_operand[7:0]) *
                             16'(i_req.source_operand[7:0])};
        end
      end
      OP_EXTEND_SIGN: begin
        comb_rsp.result = {16'h0000, {8{i_req.dest_operand[7]}}, i_req.dest_operand[7:0]};
      end
      OP_EXTEND_ZERO: begin
        comb_rsp.result = {24'h000000, i_req.dest_operand[7:0]};
      end
      OP_TEST: begin
        comb_rsp.result = i_req.dest_operand;
      end
      OP_NEGATE: begin
        s = bin_addsub(16'h0000, i_req.dest_operand[15:0], 1'b0, 1'b1, i_req.is_word);
        comb_rsp.result = {16'h0000, s[15:0]};
        comb_rsp.carry_out = s[16];
      end
      OP_CLEAR: begin
        comb_rsp.result = RESULT_RESET;
      end
      OP_TEST_AND_SET: begin
        comb_rsp.result = {24'h000000, 1'b1, i_req.dest_operand[6:0]};
      end
      OP_UNSIGNED_DIVIDE: begin
        comb_rsp.result = i_req.dest_operand;
      end
      default: begin
        comb_rsp.result = i_req.dest_operand;
      end
    endcase
  end

  // Divider trial step, kept outside the clocked process
  assign div_trial = {rem_q, quo_q[15]} - {17'h00000, divisor_q};

  // Sequencer; a divide by zero returns the dividend unchanged with a flag
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= ST_IDLE;
      done_q <= 1'b0;
      rsp_q <= '0;
      rem_q <= 32'h0000_0000;
      quo_q <= 16'h0000;
      divisor_q <= 16'h0000;
      steps_q <= 5'h00;
      word_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (i_start) begin
            if (i_req.op == OP_UNSIGNED_DIVIDE) begin
              if ((i_req.is_word && i_req.source_operand == 16'h0000) ||
                  (!i_req.is_word && i_req.source_operand[7:0] == 8'h00)) begin
                rsp_q <= '{result: i_req.dest_operand, carry_out: 1'b0, div_by_zero: 1'b1};
                done_q <= 1'b1;
              end else begin
                // Word: 32-bit dividend; byte: 16-bit dividend in low half
                word_q <= i_req.is_word;
                divisor_q <= i_req.is_word ? i_req.source_operand
                                           : {8'h00, i_req.source_operand[7:0]};
                rem_q <= i_req.is_word ? {16'h0000, i_req.dest_operand[31:16]}
                                       : {24'h000000, i_req.dest_operand[15:8]};
                quo_q <= i_req.is_word ? i_req.dest_operand[15:0]
                                       : {i_req.dest_operand[7:0], 8'h00};
                steps_q <= i_req.is_word ? 5'(DIV_WORD_STEPS) : 5'(DIV_BYTE_STEPS);
                state_q <= ST_DIVIDE;
              end
            end else begin
              rsp_q <= comb_rsp;
              done_q <= 1'b1;
            end
          end
        end
        ST_DIVIDE: begin
          // Restoring division, one quotient bit per cycle
          if (!div_trial[32]) begin
            rem_q <= div_trial[31:0];
            quo_q <= {quo_q[14:0], 1'b1};
          end else begin
            rem_q <= {rem_q[30:0], quo_q[15]};
            quo_q <= {quo_q[14:0], 1'b0};
          end
          steps_q <= steps_q - 5'h01;
          if (steps_q == 5'h01) begin
            state_q <= ST_IDLE;
            done_q <= 1'b1;
            // Remainder in upper part, quotient in lower part
            // Byte quotient bits have shifted into the low seven bits by now
            rsp_q.result <= word_q
              ? (!div_trial[32] ? {div_trial[15:0], quo_q[14:0], 1'b1}
                                : {rem_q[14:0], quo_q[15], quo_q[14:0], 1'b0})
              : (!div_trial[32] ? {16'h0000, div_trial[7:0], quo_q[6:0], 1'b1}
                                : {16'h0000, rem_q[6:0], quo_q[15], quo_q[6:0], 1'b0});
            rsp_q.carry_out <= 1'b0;
            rsp_q.div_by_zero <= 1'b0;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign o_busy = (state_q == ST_DIVIDE);
  assign o_done = done_q;
  assign o_rsp = rsp_q;

  a_carry_add: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_start && !o_busy && i_req.op == OP_ADD_WITH_CARRY && !i_req.is_word) |=>
    (o_done && o_rsp.result[7:0] == 8'($past(i_req.dest_operand[7:0]) +
     $past(i_req.source_operand[7:0]) + 8'($past(carry_in)))))
    else $error("carry add result wrong");

  a_mul_word: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_start && !o_busy && i_req.op == OP_UNSIGNED_MULTIPLY && i_req.is_word) |=>
    (o_rsp.result == $past(i_req.dest_operand[15:0]) * $past(i_req.source_operand)))
    else $error("word multiply wrong");

  sequence s_div_start;
    i_start && !o_busy && i_req.op == OP_UNSIGNED_DIVIDE && i_req.is_word &&
    i_req.source_operand != 16'h0000;
  endsequence
  // Eight iteration cycles with no answer yet
  sequence s_div_step8;
    (o_busy && !o_done) [*8];
  endsequence
  a_div_len: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    s_div_start |=> s_div_step8 ##1 s_div_step8 ##1 (o_done && !o_busy))
    else $error("divide length wrong");

  sequence s_div_byte_start;
    i_start && !o_busy && i_req.op == OP_UNSIGNED_DIVIDE && !i_req.is_word &&
    i_req.source_operand[7:0] != 8'h00;
  endsequence
  a_div_byte_len: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    s_div_byte_start |=> s_div_step8 ##1 (o_done && !o_busy))
    else $error("byte divide length wrong");

  a_div_zero: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_start && !o_busy && i_req.op == OP_UNSIGNED_DIVIDE && i_req.is_word &&
     i_req.source_operand == 16'h0000) |=> (o_done && !o_busy && o_rsp.div_by_zero))
    else $error("divide by zero not flagged");

  a_add_byte: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_start && !o_busy && i_req.op == OP_ADD && !i_req.is_word) |=>
    (o_done && o_rsp.result[31:8] == 24'h000000 &&
     {o_rsp.carry_out, o_rsp.result[7:0]} == 9'($past(i_req.dest_operand[7:0])) +
     9'($past(i_req.source_operand[7:0]))))
    else $error("byte add result wrong");

  a_bcd_digits: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    (i_start && !o_busy && i_req.op == OP_BCD_ADD && i_req.dest_operand[3:0] <= 4'h9 &&
     i_req.dest_operand[7:4] <= 4'h9 && i_req.source_operand[3:0] <= 4'h9 &&
     i_req.source_operand[7:4] <= 4'h9) |=>
    (o_done && o_rsp.result[31:8] == 24'h000000 && o_rsp.result[3:0] <= 4'h9 &&
     o_rsp.result[7:4] <= 4'h9))
    else $error("decimal add digit out of range");
endmodule

// *** include/int_arith_pkg.sv ***
package int_arith_pkg;

  // Operation codes, one per arithmetic instruction type (17 in all)
  typedef enum logic [4:0] {
    OP_ADD = 5'h00,
    OP_SUB = 5'h01,
    OP_ADD_SPECIAL = 5'h02,
    OP_SUB_SPECIAL = 5'h03,
    OP_ADD_WITH_CARRY = 5'h04,
    OP_SUB_WITH_BORROW = 5'h05,
    OP_BCD_ADD = 5'h06,
    OP_BCD_SUB = 5'h07,
    OP_UNSIGNED_MULTIPLY = 5'h08,
    OP_UNSIGNED_DIVIDE = 5'h09,
    OP_COMPARE = 5'h0A,
    OP_EXTEND_SIGN = 5'h0B,
    OP_EXTEND_ZERO = 5'h0C,
    OP_TEST = 5'h0D,
    OP_NEGATE = 5'h0E,
    OP_CLEAR = 5'h0F,
    OP_TEST_AND_SET = 5'h10
  } arith_op_t;

  // Number of distinct operation types
  localparam int unsigned NUM_OP_TYPES = 17;
  // Carry flag position inside the condition flags register
  localparam int unsigned CARRY_BIT_POS = 0;
  // Width of the condition flags register
  localparam int unsigned FLAGS_WIDTH = 8;
  // Cycles taken by the iterative divider, one per quotient bit
  localparam int unsigned DIV_WORD_STEPS = 16;
  localparam int unsigned DIV_BYTE_STEPS = 8;
  // Reset value of the result register
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

  // One request into the unit
  typedef struct packed {
    arith_op_t op;
    logic is_word;
    logic [31:0] dest_operand;
    logic [15:0] source_operand;
    logic [FLAGS_WIDTH-1:0] condition_flags_reg;
  } arith_req_t;

  // One answer out of the unit
  typedef struct packed {
    logic [31:0] result;
    logic carry_out;
    logic div_by_zero;
  } arith_rsp_t;

endpackage

// *** dv/integer_arith_unit_tb.sv ***
`timescale 1ns/1ps
module integer_arith_unit_tb;
  import int_arith_pkg::*;
  logic i_sys_clk; // 40 MHz system clock
  logic i_reset_n; // Active-low reset
  logic i_start; // Request strobe
  arith_req_t i_req; // Request bundle
  logic o_busy;
  logic o_done;
  arith_rsp_t o_rsp;
  arith_rsp_t rsp; // Last answer captured
  int err_total;
  int compares;

  integer_arith_unit i_integer_arith_unit (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_start(i_start),
    .i_req(i_req),
    .o_busy(o_busy),
    .o_done(o_done),
    .o_rsp(o_rsp)
  );

  // Clock, 25 ns period
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  // Verdict and end of run
  task automatic end_of_test();
    $display("Counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compare a data value
  task automatic cmp_val(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Compare a single flag
  task automatic cmp_bit(string what, logic exp, logic got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Compare a cycle count
  task automatic cmp_cnt(string what, int exp, int got);
    compares++;
    if (got != exp) begin
      err_total++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // One request; a stray strobe is sent mid-divide to prove it is ignored
  task automatic run_op(arith_op_t op, logic word, logic [31:0] dest, logic [15:0] src,
                        logic [7:0] flags, int lat);
    int n;
    i_req = '{op: op, is_word: word, dest_operand: dest, source_operand: src,
              condition_flags_reg: flags};
    i_start = 1'b1;
    @(posedge i_sys_clk);
    #1;
    i_start = 1'b0;
    n = 1;
    while (o_done !== 1'b1 && n < 40) begin
      cmp_bit("busy", 1'b1, o_busy);
      i_start = (n == 3);
      if (n == 3) begin
        i_req.op = OP_ADD;
      end
      @(posedge i_sys_clk);
      #1;
      i_start = 1'b0;
      n++;
    end
    cmp_cnt("latency", lat, n);
    rsp = o_rsp;
    @(posedge i_sys_clk);
    #1;
    cmp_bit("done pulse", 1'b0, o_done);
  endtask

  // Run, then check result and carry
  task automatic exec(arith_op_t op, logic word, logic [31:0] dest, logic [15:0] src,
                      logic [7:0] flags, int lat, logic [31:0] res, logic c);
    run_op(op, word, dest, src, flags, lat);
    cmp_val("result", res, rsp.result);
    cmp_bit("carry", c, rsp.carry_out);
  endtask

  // Plain add and subtract, byte results zero-extended
  task automatic t_add_sub();
    exec(OP_ADD, 1'b0, 32'h0000_12FF, 16'h0001, 8'h00, 1, 32'h0000_0000, 1'b1);
    exec(OP_SUB, 1'b0, 32'h0000_0000, 16'h0001, 8'h00, 1, 32'h0000_00FF, 1'b1);
    exec(OP_ADD, 1'b1, 32'h0000_1234, 16'h1111, 8'h00, 1, 32'h0000_2345, 1'b0);
    exec(OP_ADD_SPECIAL, 1'b1, 32'h00FF, 16'h0001, 8'h00, 1, 32'h0100, 1'b0);
    exec(OP_SUB_SPECIAL, 1'b1, 32'h0100, 16'h0101, 8'h00, 1, 32'hFFFF, 1'b1);
    $display("t_add_sub done");
  endtask

  // Carry comes from bit 0 only; other flag bits set as decoys
  task automatic t_carry();
    exec(OP_ADD_WITH_CARRY, 1'b1, 32'h0000_FFFF, 16'h0000, 8'h01, 1, 32'h0, 1'b1);
    exec(OP_ADD_WITH_CARRY, 1'b0, 32'h0000_0010, 16'h0001, 8'hFE, 1, 32'h11, 1'b0);
    exec(OP_SUB_WITH_BORROW, 1'b0, 32'h0000_0010, 16'h000F, 8'h01, 1, 32'h0, 1'b0);
    $display("t_carry done");
  endtask

  // Packed decimal byte arithmetic with carry in
  task automatic t_bcd();
    exec(OP_BCD_ADD, 1'b0, 32'h0000_0058, 16'h0046, 8'h01, 1, 32'h05, 1'b1);
    exec(OP_BCD_SUB, 1'b0, 32'h0000_0023, 16'h0045, 8'h00, 1, 32'h78, 1'b1);
    exec(OP_BCD_ADD, 1'b0, 32'h0000_0019, 16'h0019, 8'hFE, 1, 32'h38, 1'b0);
    $display("t_bcd done");
  endtask

  // Full-width unsigned products
  task automatic t_mul();
    exec(OP_UNSIGNED_MULTIPLY, 1'b0, 32'h00FF, 16'h00FF, 8'h00, 1, 32'hFE01, 1'b0);
    exec(OP_UNSIGNED_MULTIPLY, 1'b1, 32'h0000_FFFF, 16'hFFFF, 8'h00, 1, 32'hFFFE_0001,
         1'b0);
    $display("t_mul done");
  endtask

  // Iterative divide, both sizes, plus zero divisor
  task automatic t_div();
    exec(OP_UNSIGNED_DIVIDE, 1'b1, 32'h0001_0005, 16'h0010, 8'h00, 17, 32'h0005_1000,
         1'b0);
    exec(OP_UNSIGNED_DIVIDE, 1'b0, 32'h0000_0064, 16'h0007, 8'h00, 9, 32'h0000_020E,
         1'b0);
    cmp_bit("div zero flag", 1'b0, rsp.div_by_zero);
    exec(OP_UNSIGNED_DIVIDE, 1'b1, 32'hABCD_1234, 16'h0000, 8'h00, 1, 32'hABCD_1234,
         1'b0);
    cmp_bit("div zero flag", 1'b1, rsp.div_by_zero);
    $display("t_div done");
  endtask

  // Remaining types: compare keeps dest, the rest answer in one cycle
  task automatic t_others();
    exec(OP_COMPARE, 1'b1, 32'h0000_0005, 16'h0006, 8'h00, 1, 32'h0000_0005, 1'b1);
    exec(OP_EXTEND_SIGN, 1'b1, 32'h8081, 16'h0003, 8'h00, 1, 32'hFF81, 1'b0);
    exec(OP_EXTEND_ZERO, 1'b1, 32'h8081, 16'h0003, 8'h00, 1, 32'h0081, 1'b0);
    exec(OP_TEST, 1'b1, 32'h8081, 16'h0003, 8'h00, 1, 32'h8081, 1'b0);
    exec(OP_NEGATE, 1'b1, 32'h8081, 16'h0003, 8'h00, 1, 32'h7F7F, 1'b1);
    exec(OP_CLEAR, 1'b1, 32'h8081, 16'h0003, 8'h00, 1, RESULT_RESET, 1'b0);
    exec(OP_TEST_AND_SET, 1'b0, 32'h0005, 16'h0003, 8'h00, 1, 32'h0085, 1'b0);
    $display("t_others done");
  endtask

  // Reset in the middle of a divide returns the unit to idle
  task automatic t_reset_mid();
    i_req = '{op: OP_UNSIGNED_DIVIDE, is_word: 1'b1, dest_operand: 32'h0000_0100,
              source_operand: 16'h0003, condition_flags_reg: 8'h00};
    i_start = 1'b1;
    @(posedge i_sys_clk);
    #1;
    i_start = 1'b0;
    repeat (3) @(posedge i_sys_clk);
    #1;
    i_reset_n = 1'b0;
    #1;
    cmp_bit("mid reset busy", 1'b0, o_busy);
    cmp_val("mid reset result", RESULT_RESET, o_rsp.result);
    @(posedge i_sys_clk);
    #1;
    i_reset_n = 1'b1;
    exec(OP_ADD, 1'b1, 32'h0000_0001, 16'h0002, 8'h00, 1, 32'h0000_0003, 1'b0);
    $display("t_reset_mid done");
  endtask

  // Watchdog, far beyond the roughly 80 cycles the tests need
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    err_total++;
    $display("Error watchdog expected done seen hang");
    end_of_test();
  end

  // Main sequence
  initial begin
    err_total = 0;
    compares = 0;
    i_reset_n = 1'b0;
    i_start = 1'b0;
    i_req = '0;
    repeat (3) @(posedge i_sys_clk);
    #1;
    cmp_bit("reset busy", 1'b0, o_busy);
    cmp_bit("reset done", 1'b0, o_done);
    cmp_val("reset result", RESULT_RESET, o_rsp.result);
    i_reset_n = 1'b1;
    t_add_sub();
    t_carry();
    t_bcd();
    t_mul();
    t_div();
    t_others();
    t_reset_mid();
    end_of_test();
  end
endmodule
